// ---- core/ext_port_pkg.sv ----
package ext_port_pkg;
    localparam int CHANNELS       = 2;
    localparam int ADDR_W         = 32;
    localparam int COUNT_W        = 12;
    localparam int MAX_COUNT      = 4095;
    localparam int FIFO_DEPTH     = 8;
    localparam int LEVEL_W        = 4;
    localparam int WFIFO_DEPTH    = 4;
    localparam int WLEVEL_W       = 3;
    localparam int CS_W           = 2;
    localparam int CFG_READ_TICKS = 4;
    localparam logic [31:0] RESET_ADDR = 32'h0;

    typedef enum logic [1:0] {
        SIZE_8  = 2'h0,
        SIZE_16 = 2'h1,
        SIZE_32 = 2'h2
    } item_size_t;

    typedef enum logic [1:0] {
        CFG_IDLE  = 2'h0,
        CFG_READ  = 2'h1,
        CFG_WRITE = 2'h2
    } cfg_state_t;

    function automatic logic [31:0] sizeBytes(input item_size_t s);
        case (s)
            SIZE_8:  sizeBytes = 32'h1;
            SIZE_16: sizeBytes = 32'h2;
            default: sizeBytes = 32'h4;
        endcase
    endfunction : sizeBytes
endpackage : ext_port_pkg

// ---- core/read_fifo.sv ----
`timescale 1ns/1ps
`default_nettype none
module read_fifo
    import ext_port_pkg::*;
#(
    parameter int WIDTH = 32,
    parameter int DEPTH = FIFO_DEPTH,
    parameter int LW    = LEVEL_W
) (
    input  wire logic             clk,
    input  wire logic             rst,
    input  wire logic             flush,
    input  wire logic             inValid,
    input  wire logic [WIDTH-1:0] inData,
    output logic                  inReady,
    output logic                  outValid,
    input  wire logic             outReady,
    output logic [WIDTH-1:0]      outData,
    output logic [LW-1:0]         level
);
    logic [WIDTH-1:0]       mem [DEPTH];
    logic [$clog2(DEPTH)-1:0] wrIdx;
    logic [$clog2(DEPTH)-1:0] rdIdx;
    wire push = inValid && inReady;
    wire pop  = outValid && outReady;

    assign inReady  = (level != LW'(DEPTH));
    assign outValid = (level != '0);
    assign outData  = mem[rdIdx];

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            wrIdx <= '0;
            rdIdx <= '0;
            level <= '0;
        end else if (flush) begin
            wrIdx <= '0;
            rdIdx <= '0;
            level <= '0;
        end else begin
            if (push) wrIdx <= wrIdx + 1'b1;
            if (pop)  rdIdx <= rdIdx + 1'b1;
            level <= level + LW'(push) - LW'(pop);
        end
    end

    always_ff @(posedge clk) begin
        if (push) mem[wrIdx] <= inData;
    end
endmodule : read_fifo
`default_nettype wire

// ---- core/ext_parallel_port.sv ----
`timescale 1ns/1ps
`default_nettype none
module ext_parallel_port
    import ext_port_pkg::*;
(
    input  wire logic                clk,
    input  wire logic                rst,
    input  wire logic                cfgChan,
    input  wire logic                cfgStrobe,
    input  wire item_size_t          cfgSize,
    input  wire logic [ADDR_W-1:0]   cfgAddr,
    input  wire logic                startStrobe,
    input  wire logic                stopStrobe,
    input  wire logic                readChannelSel,
    input  wire logic [COUNT_W-1:0]  itemCount,
    output logic                     extRdReq,
    output logic [ADDR_W-1:0]        extRdAddr,
    output item_size_t               extRdSize,
    input  wire logic                extRdValid,
    input  wire logic [31:0]         extRdData,
    output logic                     fifoValid,
    input  wire logic                fifoPop,
    output logic [31:0]              fifoData,
    output logic [LEVEL_W-1:0]       fifoLevel,
    output logic [COUNT_W-1:0]       remaining0,
    output logic [COUNT_W-1:0]       remaining1,
    input  wire logic                hb16Mode,
    input  wire logic                cfgRdStrobe,
    input  wire logic                cfgWrStrobe,
    input  wire logic [CS_W-1:0]     chipSelectIndex,
    input  wire logic [31:0]         psramCfgValue,
    output logic                     psramCfgRdEn,
    output logic                     psramCfgWrEn,
    output logic [CS_W-1:0]          psramCs,
    output logic [31:0]              psramCfgOut,
    input  wire logic [31:0]         psramCfgIn,
    output logic [31:0]              cfgValueDest,
    input  wire logic                wfifoPush,
    input  wire logic                wfifoPop,
    output logic [WLEVEL_W-1:0]      wfifoFree
);
    logic [ADDR_W-1:0]  addr   [CHANNELS];
    item_size_t         size   [CHANNELS];
    logic [COUNT_W-1:0] remain [CHANNELS];
    logic               busyCh;
    logic               fifoIn;
    logic               fifoReady;
    logic [31:0]        fifoOut;
    logic               fifoOutValid;
    logic [LEVEL_W-1:0] level;
    cfg_state_t         cfgState;
    logic [2:0]         cfgTick;
    logic [WLEVEL_W-1:0] wUsed;

    // Channel 0 wins when both have work; fixed priority, so channel 1 waits until channel 0 has none left
    wire act0 = (remain[0] != '0);
    wire act1 = (remain[1] != '0);
    wire pick = act0 ? 1'b0 : 1'b1;
    wire anyAct = act0 || act1;
    wire validStart = startStrobe && (itemCount != '0);
    // Response dropped if its channel was cancelled meanwhile
    wire accept = extRdReq && extRdValid && (remain[busyCh] != '0);
    wire cancelBusy = stopStrobe && (readChannelSel == busyCh);
    wire [ADDR_W-1:0] nextAddr = addr[busyCh] + sizeBytes(size[busyCh]);
    // One outstanding read; request only while the FIFO has a free slot for it
    wire canIssue = anyAct && fifoReady && !extRdReq;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            for (int i = 0; i < CHANNELS; i++) begin
                addr[i]   <= RESET_ADDR;
                size[i]   <= SIZE_8;
                remain[i] <= '0;
            end
            extRdReq  <= 1'b0;
            busyCh    <= 1'b0;
            extRdAddr <= '0;
            extRdSize <= SIZE_8;
        end else begin
            if (cfgStrobe) begin
                addr[cfgChan] <= cfgAddr;
                size[cfgChan] <= cfgSize;
            end
            if (accept) begin
                remain[busyCh] <= remain[busyCh] - 1'b1;
                addr[busyCh]   <= nextAddr;
            end
            if (validStart) remain[readChannelSel] <= itemCount;
            if (stopStrobe) remain[readChannelSel] <= '0;
            if (extRdReq && (extRdValid || cancelBusy))
                extRdReq <= 1'b0;
            else if (canIssue) begin
                extRdReq  <= 1'b1;
                busyCh    <= pick;
                extRdAddr <= addr[pick];
                extRdSize <= size[pick];
            end
        end
    end

    assign fifoIn = accept;
    read_fifo #(.WIDTH(32), .DEPTH(FIFO_DEPTH), .LW(LEVEL_W)) rxFifo (
        .clk      (clk),
        .rst      (rst),
        .flush    (1'b0),
        .inValid  (fifoIn),
        .inData   (extRdData),
        .inReady  (fifoReady),
        .outValid (fifoOutValid),
        .outReady (fifoPop && fifoValid),
        .outData  (fifoOut),
        .level    (level)
    );

    // Registered head; valid rests a cycle after a pop while data catches up
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            fifoValid  <= 1'b0;
            fifoData   <= '0;
            fifoLevel  <= '0;
            remaining0 <= '0;
            remaining1 <= '0;
        end else begin
            fifoValid  <= fifoOutValid && !(fifoPop && fifoValid);
            fifoData   <= fifoOut;
            fifoLevel  <= level;
            remaining0 <= remain[0];
            remaining1 <= remain[1];
        end
    end

    // PSRAM configuration access; requests outside 16-bit mode ignored
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            cfgState     <= CFG_IDLE;
            cfgTick      <= '0;
            psramCfgRdEn <= 1'b0;
            psramCfgWrEn <= 1'b0;
            psramCs      <= '0;
            psramCfgOut  <= '0;
            cfgValueDest <= '0;
        end else begin
            case (cfgState)
                CFG_IDLE: begin
                    cfgTick <= '0;
                    if (hb16Mode && cfgRdStrobe) begin
                        cfgState     <= CFG_READ;
                        psramCs      <= chipSelectIndex;
                        psramCfgRdEn <= 1'b1;
                    end else if (hb16Mode && cfgWrStrobe) begin
                        cfgState     <= CFG_WRITE;
                        psramCs      <= chipSelectIndex;
                        psramCfgOut  <= psramCfgValue;
                        psramCfgWrEn <= 1'b1;
                    end
                end
                CFG_READ: begin
                    cfgTick <= cfgTick + 1'b1;
                    if (cfgTick == 3'(CFG_READ_TICKS - 1)) begin
                        cfgValueDest <= psramCfgIn;
                        psramCfgRdEn <= 1'b0;
                        cfgState     <= CFG_IDLE;
                    end
                end
                default: begin
                    psramCfgWrEn <= 1'b0;
                    cfgState     <= CFG_IDLE;
                end
            endcase
        end
    end

    // Write transaction FIFO occupancy
    wire wInc = wfifoPush && (wUsed != WLEVEL_W'(WFIFO_DEPTH));
    wire wDec = wfifoPop && (wUsed != '0);
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            wUsed     <= '0;
            wfifoFree <= WLEVEL_W'(WFIFO_DEPTH);
        end else begin
            wUsed     <= wUsed + WLEVEL_W'(wInc) - WLEVEL_W'(wDec);
            wfifoFree <= WLEVEL_W'(WFIFO_DEPTH) - (wUsed + WLEVEL_W'(wInc)
                         - WLEVEL_W'(wDec));
        end
    end

    default clocking assertClk @(posedge clk);
    endclocking
    default disable iff (rst);

    // Enable stands for the whole read window, then drops
    sequence rdEnWindow;
        psramCfgRdEn[*4] ##1 !psramCfgRdEn;
    endsequence : rdEnWindow

    chk_cancel_idle: assert property (
        stopStrobe |=> remain[$past(readChannelSel)] == '0)
        else $error("cancel left count");
    chk_cancel_drop: assert property (
        extRdReq && cancelBusy |=> !extRdReq)
        else $error("read kept after cancel");
    chk_full_pause: assert property (
        !fifoReady && !extRdReq |=> !extRdReq)
        else $error("fetch while full");
    chk_rden_hold: assert property (
        $rose(psramCfgRdEn) |-> rdEnWindow)
        else $error("read enable length");
    chk_wren_pulse: assert property (
        $rose(psramCfgWrEn) |=> !psramCfgWrEn)
        else $error("write strobe length");
    chk_free_slots: assert property (
        wfifoPush && !wfifoPop && wfifoFree != '0 |=>
        wfifoFree == $past(wfifoFree) - WLEVEL_W'(1))
        else $error("free slot mismatch");
    chk_start_load: assert property (
        validStart && !stopStrobe |=> remain[$past(readChannelSel)]
        == $past(itemCount))
        else $error("start count");
    chk_addr_step: assert property (
        accept && !cfgStrobe |=> addr[$past(busyCh)] ==
        $past(extRdAddr) + sizeBytes($past(extRdSize)))
        else $error("address step");
    chk_level_copy: assert property (
        fifoIn && !(fifoPop && fifoValid) |=> ##1
        fifoLevel == $past(fifoLevel) + LEVEL_W'(1))
        else $error("level report");
endmodule : ext_parallel_port
`default_nettype wire

// ---- verification/ext_mem_model.sv ----
`timescale 1ns/1ps
`default_nettype none
module ext_mem_model
    import ext_port_pkg::*;
(
    input  wire logic              clk,
    input  wire logic              rst,
    input  wire logic              slow,
    input  wire logic              extRdReq,
    input  wire logic [ADDR_W-1:0] extRdAddr,
    output logic                   extRdValid,
    output logic [31:0]            extRdData,
    input  wire logic              psramCfgRdEn,
    input  wire logic [CS_W-1:0]   psramCs,
    output logic [31:0]            psramCfgIn
);
    logic [2:0] waitCnt;
    logic       hold;
    logic [31:0] cfgWord;
    assign cfgWord = 32'h5A0000C0 | 32'(psramCs);
    // Idle config bus shows the inverse so stale capture is caught
    assign psramCfgIn = psramCfgRdEn ? cfgWord : ~cfgWord;
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            waitCnt <= 3'h0;
            hold <= 1'b0;
            extRdValid <= 1'b0;
            extRdData <= 32'h0;
        end else begin
            extRdValid <= 1'b0;
            // Released data lines toggle every cycle
            extRdData <= ~extRdData;
            if (!extRdReq) begin
                hold <= 1'b0;
                waitCnt <= 3'h0;
            end else if (!hold && waitCnt >= (slow ? 3'h4 : 3'h0)) begin
                extRdValid <= 1'b1;
                extRdData <= {extRdAddr[15:0], ~extRdAddr[15:0]};
                hold <= 1'b1;
            end else if (!hold) begin
                waitCnt <= waitCnt + 3'h1;
            end
        end
    end
endmodule : ext_mem_model
`default_nettype wire

// ---- verification/tb_top.sv ----
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    import ext_port_pkg::*;
    logic clk = 0, rst = 1, slow = 0;
    logic cfgChan = 0, cfgStrobe = 0, startStrobe = 0, stopStrobe = 0;
    logic readChannelSel = 0, fifoPop = 0, hb16Mode = 0;
    logic cfgRdStrobe = 0, cfgWrStrobe = 0, wfifoPush = 0, wfifoPop = 0;
    item_size_t cfgSize = SIZE_8;
    logic [31:0] cfgAddr = 0, psramCfgValue = 0;
    logic [COUNT_W-1:0] itemCount = 0;
    logic [CS_W-1:0] chipSelectIndex = 0;
    logic extRdReq, extRdValid, fifoValid, psramCfgRdEn, psramCfgWrEn;
    logic [31:0] extRdAddr, extRdData, fifoData, psramCfgOut;
    logic [31:0] psramCfgIn, cfgValueDest;
    item_size_t extRdSize;
    logic [LEVEL_W-1:0] fifoLevel;
    logic [COUNT_W-1:0] remaining0, remaining1;
    logic [CS_W-1:0] psramCs;
    logic [WLEVEL_W-1:0] wfifoFree;
    int n_errors = 0, n_checks = 0, n;
    logic [31:0] lastCfg = 32'h0;
    always #4 clk = ~clk;
    ext_parallel_port dut_u (.*);
    ext_mem_model mem_u (.*);
    task tick; @(posedge clk); #1; endtask : tick
    task wrap_up;
        if (n_errors == 0 && n_checks > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask : wrap_up
    task chk(input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            n_errors++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : chk
    function logic sig(input int w);
        return w == 0 ? fifoValid : (w == 1 ? psramCfgRdEn : psramCfgWrEn);
    endfunction : sig
    task wait_on(input int w);
        int k;
        for (k = 0; k < 200 && sig(w) !== 1'b1; k++) tick;
        if (k == 200) begin
            n_errors++;
            wrap_up;
        end
    endtask : wait_on
    task cfg(input logic c, input item_size_t s, input logic [31:0] a);
        cfgChan = c; cfgSize = s; cfgAddr = a; cfgStrobe = 1;
        tick;
        cfgStrobe = 0;
    endtask : cfg
    task start(input logic c, input logic [COUNT_W-1:0] cnt);
        readChannelSel = c; itemCount = cnt; startStrobe = 1;
        tick;
        startStrobe = 0;
    endtask : start
    task pop_items(input logic [31:0] a, step, mask, input int cnt);
        for (int i = 0; i < cnt; i++) begin
            wait_on(0);
            chk(fifoData & mask, {a[15:0], ~a[15:0]} & mask);
            fifoPop = 1;
            tick;
            fifoPop = 0;
            tick;
            a = a + step;
        end
    endtask : pop_items
    initial begin
        repeat (6) @(posedge clk);
        #1 rst = 0;
        tick;
        chk(wfifoFree, 32'h4);
        cfg(0, SIZE_32, 32'h100);
        start(0, 12'hA);
        repeat (60) tick;
        chk(fifoLevel, FIFO_DEPTH);
        chk(extRdReq, 1'b0);
        chk(remaining0, 12'h2);
        pop_items(32'h100, 32'h4, 32'hFFFFFFFF, 10);
        repeat (4) tick;
        chk(remaining0, 12'h0);
        chk(fifoLevel, 4'h0);
        start(0, 12'h2);
        pop_items(32'h128, 32'h4, 32'hFFFFFFFF, 2);
        start(0, 12'h0);
        repeat (4) tick;
        chk(extRdReq, 1'b0);
        // Slow far side on the second channel: 16-bit items, then a cancelled 8-bit run
        slow = 1;
        cfg(1, SIZE_16, 32'h20);
        start(1, 12'h3);
        tick;
        chk(extRdSize, SIZE_16);
        pop_items(32'h20, 32'h2, 32'hFFFF, 3);
        cfg(1, SIZE_8, 32'h40);
        start(1, 12'h6);
        repeat (3) tick;
        stopStrobe = 1;
        tick;
        stopStrobe = 0;
        repeat (12) tick;
        chk(remaining1, 12'h0);
        chk(extRdReq, 1'b0);
        chk(fifoValid, 1'b0);
        slow = 0;
        // Config access is refused outside 16-bit host-bus mode
        cfgRdStrobe = 1;
        tick;
        cfgRdStrobe = 0;
        repeat (8) tick;
        chk(psramCfgRdEn, 1'b0);
        hb16Mode = 1;
        for (int cs = 0; cs < 4; cs++) begin
            chipSelectIndex = cs[1:0];
            cfgRdStrobe = 1;
            tick;
            cfgRdStrobe = 0;
            wait_on(1);
            chk(psramCs, cs);
            // Destination untouched while the enable still stands
            chk(cfgValueDest, lastCfg);
            for (n = 0; n < 20 && psramCfgRdEn === 1'b1; n++) tick;
            chk(n, CFG_READ_TICKS);
            chk(cfgValueDest, 32'h5A0000C0 | cs);
            lastCfg = 32'h5A0000C0 | cs;
        end
        chipSelectIndex = 1;
        psramCfgValue = 32'h1234ABCD;
        cfgWrStrobe = 1;
        tick;
        cfgWrStrobe = 0;
        wait_on(2);
        chk(psramCfgOut, 32'h1234ABCD);
        chk(psramCs, 2'h1);
        tick;
        chk(psramCfgWrEn, 1'b0);
        // One push beyond capacity must not wrap the count
        repeat (5) begin
            wfifoPush = 1;
            tick;
            wfifoPush = 0;
            tick;
        end
        chk(wfifoFree, 3'h0);
        wfifoPop = 1;
        tick;
        wfifoPop = 0;
        tick;
        chk(wfifoFree, 3'h1);
        wrap_up;
    end
endmodule : tb_top
`default_nettype wire
